// ---- stsw_pkg.sv ----
// Purpose: Shared constants and types for the target select-wait command engine.
// Assumes: One 100 MHz clock, synchronous active-low reset.
// Notes: Bus signals are active high inside the design; pads invert.
package stsw_pkg;
  // ==========================================================================
  // Command decode
  localparam logic [7:0] STSW_WFS_CMD_VAL = 8'he4;
  localparam logic [7:0] STSW_WFS_CMD_MSK = 8'hfe;
  localparam logic [7:0] STSW_SEQ_CMD_VAL = 8'hf4;
  localparam logic [7:0] STSW_SEQ_CMD_MSK = 8'hfc;
  localparam int STSW_MOD_BIT = 1;
  // ==========================================================================
  // Message/command space
  localparam int STSW_SCRIPTS = 6;
  localparam int STSW_SCRIPT_BYTES = 32;
  localparam int STSW_MCS_AW = 8;
  localparam int STSW_MCS_DEPTH = STSW_SCRIPTS * STSW_SCRIPT_BYTES;
  // ==========================================================================
  // Messages and fields
  localparam logic [7:0] STSW_MSG_DISCONNECT = 8'h04;
  localparam int STSW_IDENT_BIT = 7;
  localparam int STSW_DISC_OK_BIT = 6;
  localparam logic [7:0] STSW_TAG_LO = 8'h20;
  localparam logic [7:0] STSW_TAG_HI = 8'h22;
  localparam int STSW_RESEL_BIT = 5;
  localparam int STSW_CMD_LEN_W = 5;
  // ==========================================================================
  // Software register offsets
  localparam logic [3:0] STSW_REG_CMD = 4'h0;
  localparam logic [3:0] STSW_REG_PTR = 4'h1;
  localparam logic [3:0] STSW_REG_CTRL = 4'h2;
  localparam logic [3:0] STSW_REG_AUX = 4'h3;
  localparam logic [3:0] STSW_REG_BUF = 4'h4;
  localparam logic [3:0] STSW_REG_WPOS = 4'h5;
  // Control register bits.
  localparam int STSW_CTRL_SELEN = 0;
  localparam int STSW_CTRL_OVRD = 1;
  localparam int STSW_CTRL_ABORT = 2;
  // Aux status bits.
  localparam int STSW_AUX_BUSY = 0;
  localparam int STSW_AUX_DONE = 1;
  localparam int STSW_AUX_CONERR = 2;
  localparam int STSW_AUX_ATNERR = 3;
  localparam int STSW_AUX_MSGERR = 4;
  localparam int STSW_AUX_INIT = 6;
  localparam int STSW_AUX_ABORTED = 7;

  typedef enum {
    STSW_IDLE, STSW_WAIT_SEL, STSW_SEL_REL, STSW_RESEL_REL, STSW_ID_STORE,
    STSW_IDENT, STSW_TAG1, STSW_TAG2, STSW_CMD, STSW_DISC, STSW_BUSREL,
    STSW_WFR
  } stsw_state_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } stsw_sw_req_t;

  // Bus inputs: bus id lines, and a byte strobe with data from the initiator.
  typedef struct packed {
    logic sel;
    logic resel;
    logic atn;
    logic connected;
    logic [7:0] id;
    logic byte_vld;
    logic [7:0] data;
  } stsw_bus_in_t;

  typedef struct packed {
    logic bsy;
    logic send_vld;
    logic [7:0] send_data;
  } stsw_bus_out_t;
endpackage

// ---- stsw_engine.sv ----
// Purpose: Target wait-for-select command and full select sequence engine.
// Assumes: Bus handshake is abstracted to one-cycle byte strobes.
// Notes: Message/command space is a local byte array written by the engine.
//
// Behaviour
// - Code 1110 010X decodes as the wait-for-select command using the script space.
// - Code 1111 01XX decodes as the full target select sequence.
// - Wait-for-select waits for select or reselect, then stores the selector ID.
// - On select or reselect, assert busy and wait for select release.
// - Selection keeps target mode; reselection switches to initiator mode.
// - After reselection, busy drops only once select has been released.
// - Aux bit 5 marks reselection; software reads it before the ID.
// - Wait-for-select aborts with connect error if already connected at start.
// - Soft abort ends wait-for-select only before any selection.
// - Reselection during the sequence goes initiator and enters reselect wait.
// - Sequence stores ID, asserts busy, then identify under attention.
// - Attention still on with modifier set receives and stores two-byte tag.
// - Sequence then receives and stores the command bytes.
// - Disconnect allowed and no override sends DISCONNECT; forbidden stops.
// - After DISCONNECT, busy is released toward bus free.
// - Abort on unexpected attention in command or disconnect, or connected start.
// - Only identify then tag accepted; others abort, stored in script space.
// - Soft abort of sequence acts only before selection; a later one is cleared unused once idle.
// - Script holds ID, identify, tag, command, from the script pointer.
// - Script space is six scripts of 32 bytes each.
`timescale 1ns/1ps
`default_nettype none
module stsw_engine #(
  parameter int CMD_BYTES = 6
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // Software port
  input wire stsw_pkg::stsw_sw_req_t sw_req,
  output logic [7:0] sw_rdata,
  // SCSI bus side
  input wire stsw_pkg::stsw_bus_in_t bus_in,
  output stsw_pkg::stsw_bus_out_t bus_out,
  output logic initiator_mode
);
  import stsw_pkg::*;

  typedef struct packed {
    stsw_state_t st;
    logic [7:0] cmd;
    logic [STSW_MCS_AW-1:0] ptr;
    logic [STSW_MCS_AW-1:0] wpos;
    logic [2:0] ctrl;
    logic [7:0] aux;
    logic [7:0] rdata;
    logic bsy;
    logic send_vld;
    logic [7:0] send_data;
    logic init_mode;
    logic seq;
    logic disc_ok;
    logic [STSW_CMD_LEN_W-1:0] ccnt;
  } stsw_regs_t;

  stsw_regs_t r_q;
  stsw_regs_t r_d;
  logic [7:0] mcs_q [STSW_MCS_DEPTH];
  logic mcs_we;
  logic [7:0] mcs_wd;

  function automatic logic cmd_match(input logic [7:0] c, input logic [7:0] v,
                                     input logic [7:0] m);
    cmd_match = ((c & m) == v);
  endfunction

  // ==========================================================================
  // Next-state logic
  always_comb begin
    r_d = r_q;
    mcs_we = 1'b0;
    mcs_wd = 8'h00;
    r_d.send_vld = 1'b0;
    r_d.rdata = 8'h00;
    // Software port.
    if (sw_req.rd) begin
      case (sw_req.addr)
        STSW_REG_CMD: r_d.rdata = r_q.cmd;
        STSW_REG_PTR: r_d.rdata = r_q.ptr;
        STSW_REG_CTRL: r_d.rdata = {5'h00, r_q.ctrl};
        STSW_REG_AUX: r_d.rdata = r_q.aux;
        STSW_REG_BUF: begin
          // The buffer shows the script byte at the pointer, so software can walk a script.
          if (r_q.ptr < STSW_MCS_AW'(STSW_MCS_DEPTH)) begin
            r_d.rdata = mcs_q[r_q.ptr];
          end
        end
        STSW_REG_WPOS: r_d.rdata = r_q.wpos;
        default: r_d.rdata = 8'h00;
      endcase
    end
    if (sw_req.wr) begin
      case (sw_req.addr)
        STSW_REG_CMD: begin
          if (r_q.st == STSW_IDLE) begin
            r_d.cmd = sw_req.wdata;
            r_d.aux = 8'h00;
            if (cmd_match(sw_req.wdata, STSW_WFS_CMD_VAL, STSW_WFS_CMD_MSK) ||
                cmd_match(sw_req.wdata, STSW_SEQ_CMD_VAL, STSW_SEQ_CMD_MSK)) begin
              r_d.seq = cmd_match(sw_req.wdata, STSW_SEQ_CMD_VAL, STSW_SEQ_CMD_MSK);
              r_d.wpos = r_q.ptr;
              r_d.aux[STSW_AUX_BUSY] = 1'b1;
              if (bus_in.connected) begin
                r_d.aux[STSW_AUX_CONERR] = 1'b1;
                r_d.aux[STSW_AUX_BUSY] = 1'b0;
              end else begin
                r_d.st = STSW_WAIT_SEL;
              end
            end
          end
        end
        STSW_REG_PTR: r_d.ptr = sw_req.wdata;
        STSW_REG_CTRL: r_d.ctrl = sw_req.wdata[2:0];
        default: ;
      endcase
    end
    // Soft abort is honoured only where it is safe.
    if (r_q.ctrl[STSW_CTRL_ABORT] && r_q.st == STSW_WAIT_SEL) begin
      r_d.st = STSW_IDLE;
      r_d.aux[STSW_AUX_ABORTED] = 1'b1;
      r_d.aux[STSW_AUX_BUSY] = 1'b0;
      r_d.ctrl[STSW_CTRL_ABORT] = 1'b0;
    end else begin
      case (r_q.st)
        STSW_IDLE: r_d.ctrl[STSW_CTRL_ABORT] = 1'b0;
        STSW_WAIT_SEL: begin
          if (r_q.ctrl[STSW_CTRL_SELEN] && (bus_in.sel || bus_in.resel)) begin
            r_d.bsy = 1'b1;
            mcs_we = 1'b1;
            mcs_wd = bus_in.id;
            r_d.wpos = r_q.wpos + 8'h01;
            r_d.aux[STSW_RESEL_BIT] = bus_in.resel;
            if (bus_in.resel) begin
              r_d.init_mode = 1'b1;
              r_d.aux[STSW_AUX_INIT] = 1'b1;
              r_d.st = STSW_RESEL_REL;
            end else begin
              r_d.st = STSW_SEL_REL;
            end
          end
        end
        STSW_RESEL_REL: begin
          if (!bus_in.sel) begin
            r_d.bsy = 1'b0;
            r_d.st = r_q.seq ? STSW_WFR : STSW_BUSREL;
          end
        end
        STSW_SEL_REL: begin
          if (!bus_in.sel) begin
            if (!r_q.seq) begin
              // A plain selection leaves the target connected, so busy stays up.
              r_d.aux[STSW_AUX_DONE] = 1'b1;
              r_d.st = STSW_IDLE;
            end else if (bus_in.atn) begin
              r_d.st = STSW_IDENT;
            end else begin
              r_d.disc_ok = 1'b0;
              r_d.st = STSW_CMD;
              r_d.ccnt = '0;
            end
          end
        end
        STSW_IDENT, STSW_TAG1, STSW_TAG2: begin
          if (bus_in.byte_vld) begin
            mcs_we = 1'b1;
            mcs_wd = bus_in.data;
            r_d.wpos = r_q.wpos + 8'h01;
            r_d.ccnt = '0;
            r_d.st = STSW_CMD;
            if (r_q.st == STSW_IDENT) begin
              if (!bus_in.data[STSW_IDENT_BIT]) begin
                r_d.aux[STSW_AUX_MSGERR] = 1'b1;
                r_d.st = STSW_IDLE;
              end else begin
                r_d.disc_ok = bus_in.data[STSW_DISC_OK_BIT];
                if (bus_in.atn && r_q.cmd[STSW_MOD_BIT]) begin
                  r_d.st = STSW_TAG1;
                end
              end
            end else if (r_q.st == STSW_TAG1) begin
              if (bus_in.data < STSW_TAG_LO || bus_in.data > STSW_TAG_HI) begin
                r_d.aux[STSW_AUX_MSGERR] = 1'b1;
                r_d.st = STSW_IDLE;
              end else begin
                r_d.st = STSW_TAG2;
              end
            end
          end
        end
        STSW_CMD: begin
          if (bus_in.atn) begin
            r_d.aux[STSW_AUX_ATNERR] = 1'b1;
            r_d.st = STSW_IDLE;
          end else if (bus_in.byte_vld) begin
            mcs_we = 1'b1;
            mcs_wd = bus_in.data;
            r_d.wpos = r_q.wpos + 8'h01;
            r_d.ccnt = r_q.ccnt + 1'b1;
            if (r_q.ccnt == STSW_CMD_LEN_W'(CMD_BYTES - 1)) begin
              if (r_q.disc_ok && !r_q.ctrl[STSW_CTRL_OVRD]) begin
                r_d.st = STSW_DISC;
              end else begin
                r_d.st = STSW_IDLE;
                r_d.aux[STSW_AUX_DONE] = 1'b1;
              end
            end
          end
        end
        STSW_DISC: begin
          if (bus_in.atn) begin
            r_d.aux[STSW_AUX_ATNERR] = 1'b1;
            r_d.st = STSW_IDLE;
          end else begin
            r_d.send_vld = 1'b1;
            r_d.send_data = STSW_MSG_DISCONNECT;
            r_d.st = STSW_BUSREL;
          end
        end
        STSW_BUSREL: begin
          if (!r_q.init_mode) begin
            r_d.bsy = 1'b0;
          end
          r_d.aux[STSW_AUX_DONE] = 1'b1;
          r_d.st = STSW_IDLE;
        end
        STSW_WFR: begin
          r_d.aux[STSW_AUX_DONE] = 1'b1;
          r_d.st = STSW_IDLE;
        end
        default: r_d.st = STSW_IDLE;
      endcase
    end
    if (r_d.st == STSW_IDLE) begin
      r_d.aux[STSW_AUX_BUSY] = 1'b0;
    end
  end

  // ==========================================================================
  // State registers
  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      r_q <= '{st: STSW_IDLE, default: '0};
    end else begin
      r_q <= r_d;
    end
  end

  // The script space has no reset; it is plain storage.
  always_ff @(posedge mclk) begin
    if (mcs_we && r_q.wpos < STSW_MCS_AW'(STSW_MCS_DEPTH)) begin
      mcs_q[r_q.wpos] <= mcs_wd;
    end
  end

  assign sw_rdata = r_q.rdata;
  assign bus_out = '{bsy: r_q.bsy, send_vld: r_q.send_vld, send_data: r_q.send_data};
  assign initiator_mode = r_q.init_mode;

  // ==========================================================================
  // Checks
  a_wfs_decode: assert property (@(posedge mclk) disable iff (!reset_n)
    (sw_req.wr && sw_req.addr == STSW_REG_CMD && r_q.st == STSW_IDLE &&
     sw_req.wdata == STSW_WFS_CMD_VAL && !bus_in.connected) |=> r_q.st == STSW_WAIT_SEL)
    else $error("wait command not started");
  a_conn_err: assert property (@(posedge mclk) disable iff (!reset_n)
    (sw_req.wr && sw_req.addr == STSW_REG_CMD && r_q.st == STSW_IDLE && bus_in.connected &&
     (cmd_match(sw_req.wdata, STSW_WFS_CMD_VAL, STSW_WFS_CMD_MSK) ||
      cmd_match(sw_req.wdata, STSW_SEQ_CMD_VAL, STSW_SEQ_CMD_MSK))) |=>
    r_q.aux[STSW_AUX_CONERR] && r_q.st == STSW_IDLE)
    else $error("connect error missed");
  a_sel_bsy: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.st == STSW_WAIT_SEL && !r_q.ctrl[STSW_CTRL_ABORT] && r_q.ctrl[STSW_CTRL_SELEN] &&
     bus_in.sel) |=> bus_out.bsy)
    else $error("busy not asserted on select");
  a_no_sel_off: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.st == STSW_WAIT_SEL && !r_q.ctrl[STSW_CTRL_SELEN]) |=>
    (r_q.st inside {STSW_WAIT_SEL, STSW_IDLE}) && $stable(bus_out.bsy))
    else $error("selected while detection off");
  a_resel_mode: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.st == STSW_RESEL_REL) |-> initiator_mode && r_q.aux[STSW_RESEL_BIT])
    else $error("reselect not marked");
  a_resel_bsy: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.st == STSW_RESEL_REL && bus_in.sel) |=> bus_out.bsy)
    else $error("busy dropped early");
  a_wpos_step: assert property (@(posedge mclk) disable iff (!reset_n)
    mcs_we |=> r_q.wpos == $past(r_q.wpos) + 8'h01)
    else $error("write position not stepped");
  a_cmd_atn: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.st == STSW_CMD && bus_in.atn) |=> r_q.st == STSW_IDLE && r_q.aux[STSW_AUX_ATNERR])
    else $error("attention abort missed");
  a_disc_bsy: assert property (@(posedge mclk) disable iff (!reset_n)
    (r_q.st == STSW_DISC && !bus_in.atn) |=> bus_out.send_vld ##1 !bus_out.bsy)
    else $error("disconnect release wrong");
  c_select: cover property (@(posedge mclk) r_q.st == STSW_SEL_REL);
  c_reselect: cover property (@(posedge mclk) r_q.st == STSW_WFR);
  c_disc: cover property (@(posedge mclk) bus_out.send_vld);
  c_msgerr: cover property (@(posedge mclk) r_q.aux[STSW_AUX_MSGERR]);
endmodule
`default_nettype wire

// ---- stsw_ini.sv ----
// Purpose: Initiator model on the bus side of the target select-wait engine.
// Assumes: Tasks are called from the bench at or after a rising mclk edge.
// Notes: Released id and data lines show the inverse of their last value.
`timescale 1ns/1ps
`default_nettype none
module stsw_ini (
  // Clock
  input wire logic mclk,
  // Bus toward the target
  output var stsw_pkg::stsw_bus_in_t bus_in,
  input wire stsw_pkg::stsw_bus_out_t bus_out
);
  import stsw_pkg::*;
  // ====================
  // Bus actions
  initial bus_in = '0;
  task automatic idle();
    bus_in <= '0;
  endtask
  task automatic pick(input logic [7:0] id, input logic rs, input logic atn);
    @(posedge mclk);
    // Select stands in both cases; the reselect line only marks which one it is.
    bus_in.sel <= 1'b1;
    bus_in.resel <= rs;
    bus_in.id <= id;
    bus_in.atn <= atn;
  endtask
  // Select is held until busy answers; a bounded wait keeps a dead target from hanging us.
  task automatic rel();
    int i;
    for (i = 0; i < 40 && bus_out.bsy !== 1'b1; i++) begin
      @(posedge mclk);
    end
    @(posedge mclk);
    bus_in.sel <= 1'b0;
    bus_in.resel <= 1'b0;
    bus_in.id <= ~bus_in.id;
  endtask
  task automatic put(input logic [7:0] b, input logic atn);
    @(posedge mclk);
    bus_in.byte_vld <= 1'b1;
    bus_in.data <= b;
    bus_in.atn <= atn;
    @(posedge mclk);
    bus_in.byte_vld <= 1'b0;
    bus_in.data <= ~b;
    repeat (2) @(posedge mclk);
  endtask
  task automatic lines(input logic conn, input logic atn);
    @(posedge mclk);
    bus_in.connected <= conn;
    bus_in.atn <= atn;
  endtask
endmodule
`default_nettype wire

// ---- scsi_target_select_wait_tb.sv ----
// Purpose: Self-checking bench for the target select-wait engine.
// Assumes: Inputs change by non-blocking assignment at rising mclk.
// Notes: Command length is cut to 4 bytes to keep runs short.
`timescale 1ns/1ps
`default_nettype none
module scsi_target_select_wait_tb;
  import stsw_pkg::*;
  localparam int CMDN = 4;
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  stsw_sw_req_t sw_req = '0;
  logic [7:0] sw_rdata;
  stsw_bus_in_t bus_in;
  stsw_bus_out_t bus_out;
  logic initiator_mode;
  logic [7:0] rd_q;
  logic [7:0] sent_cnt;
  logic [7:0] sent_byte;
  int err_count = 0;
  int tests_run = 0;
  // ====================
  // Clock, design and initiator
  always #5 mclk = ~mclk;
  stsw_engine #(.CMD_BYTES(CMDN)) stsw_engine_inst (
    .mclk(mclk), .reset_n(reset_n), .sw_req(sw_req), .sw_rdata(sw_rdata),
    .bus_in(bus_in), .bus_out(bus_out), .initiator_mode(initiator_mode));
  stsw_ini stsw_ini_inst (.mclk(mclk), .bus_in(bus_in), .bus_out(bus_out));
  always @(posedge mclk) begin
    if (!reset_n) begin
      sent_cnt <= 8'h00;
    end else if (bus_out.send_vld === 1'b1) begin
      sent_cnt <= sent_cnt + 8'h01;
      sent_byte <= bus_out.send_data;
    end
  end
  // ====================
  // Helpers
  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rst();
    @(posedge mclk);
    reset_n <= 1'b0;
    sw_req <= '0;
    stsw_ini_inst.idle();
    repeat (2) @(posedge mclk);
    reset_n <= 1'b1;
  endtask
  task automatic wr8(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    sw_req.addr <= a;
    sw_req.wdata <= d;
    sw_req.wr <= 1'b1;
    @(posedge mclk);
    sw_req.wr <= 1'b0;
  endtask
  task automatic rd8(input logic [3:0] a);
    @(posedge mclk);
    sw_req.addr <= a;
    sw_req.rd <= 1'b1;
    @(posedge mclk);
    sw_req.rd <= 1'b0;
    #1;
    rd_q = sw_rdata;
  endtask
  task automatic wait_bsy(input logic lvl);
    int i;
    for (i = 0; i < 40 && bus_out.bsy !== lvl; i++) begin
      @(posedge mclk);
      #1;
    end
    chk1(bus_out.bsy, lvl);
    if (bus_out.bsy !== lvl) tally_and_finish();
  endtask
  // Status is polled over the register port, the way software would see it.
  task automatic wait_aux(input int b);
    int i;
    rd8(STSW_REG_AUX);
    for (i = 0; i < 40 && rd_q[b] !== 1'b1; i++) rd8(STSW_REG_AUX);
    chk1(rd_q[b], 1'b1);
    if (rd_q[b] !== 1'b1) tally_and_finish();
  endtask
  task automatic start(input logic [7:0] cmd);
    rst();
    wr8(STSW_REG_PTR, 8'h20);
    wr8(STSW_REG_CTRL, 8'h01);
    wr8(STSW_REG_CMD, cmd);
  endtask
  // ====================
  // Scenarios
  task automatic t_idle();
    rd8(STSW_REG_AUX);
    chk8(rd_q, 8'h00);
    rd8(4'hf);
    chk8(rd_q, 8'h00);
    chk1(initiator_mode, 1'b0);
  endtask
  task automatic t_wait(input logic [7:0] cmd, input logic [7:0] id, input logic rs);
    start(cmd);
    stsw_ini_inst.pick(id, rs, 1'b0);
    wait_bsy(1'b1);
    repeat (3) @(posedge mclk);
    chk1(bus_out.bsy, 1'b1);
    stsw_ini_inst.rel();
    repeat (4) @(posedge mclk);
    #1;
    chk1(bus_out.bsy, ~rs);
    chk1(initiator_mode, rs);
    rd8(STSW_REG_AUX);
    chk1(rd_q[STSW_RESEL_BIT], rs);
    rd8(STSW_REG_BUF);
    chk8(rd_q, id);
  endtask
  task automatic t_nosel();
    rst();
    wr8(STSW_REG_CMD, 8'he4);
    stsw_ini_inst.pick(8'h81, 1'b0, 1'b0);
    repeat (10) @(posedge mclk);
    #1;
    chk1(bus_out.bsy, 1'b0);
  endtask
  task automatic t_seq(input logic [7:0] cmd, input logic [7:0] idn, input logic tag,
                       input logic ovr);
    int k;
    start(cmd);
    if (ovr) wr8(STSW_REG_CTRL, 8'h03);
    stsw_ini_inst.pick(8'h81, 1'b0, 1'b1);
    wait_bsy(1'b1);
    stsw_ini_inst.rel();
    stsw_ini_inst.put(idn, tag);
    if (tag) stsw_ini_inst.put(8'h22, 1'b1);
    if (tag) stsw_ini_inst.put(8'h05, 1'b0);
    for (k = 0; k < CMDN; k++) stsw_ini_inst.put(8'h30 + 8'(k), 1'b0);
    wait_aux(STSW_AUX_DONE);
    chk1(initiator_mode, 1'b0);
    rd8(STSW_REG_WPOS);
    chk8(rd_q, 8'h20 + 8'(2 + CMDN) + (tag ? 8'h02 : 8'h00));
    wr8(STSW_REG_PTR, 8'h21);
    rd8(STSW_REG_BUF);
    chk8(rd_q, idn);
    wr8(STSW_REG_PTR, 8'h22);
    rd8(STSW_REG_BUF);
    chk8(rd_q, tag ? 8'h22 : 8'h30);
  endtask
  task automatic t_bad(input logic [7:0] cmd, input logic [7:0] m0, input logic [7:0] m1,
                       input logic two);
    start(cmd);
    stsw_ini_inst.pick(8'h81, 1'b0, 1'b1);
    stsw_ini_inst.rel();
    stsw_ini_inst.put(m0, 1'b1);
    if (two) stsw_ini_inst.put(m1, 1'b1);
    wait_aux(STSW_AUX_MSGERR);
    rd8(STSW_REG_WPOS);
    chk8(rd_q, 8'h22 + {7'h00, two});
    wr8(STSW_REG_PTR, 8'h21 + {7'h00, two});
    rd8(STSW_REG_BUF);
    chk8(rd_q, two ? m1 : m0);
  endtask
  task automatic t_err(input logic [7:0] cmd, input logic conn, input int b);
    rst();
    wr8(STSW_REG_CTRL, 8'h01);
    stsw_ini_inst.lines(conn, 1'b0);
    wr8(STSW_REG_CMD, cmd);
    if (!conn) stsw_ini_inst.pick(8'h81, 1'b0, 1'b0);
    if (!conn) stsw_ini_inst.rel();
    if (!conn) stsw_ini_inst.put(8'h12, 1'b0);
    if (!conn) stsw_ini_inst.lines(1'b0, 1'b1);
    wait_aux(b);
  endtask
  task automatic t_abort(input logic [7:0] cmd);
    start(cmd);
    wr8(STSW_REG_CTRL, 8'h05);
    wait_aux(STSW_AUX_ABORTED);
    stsw_ini_inst.pick(8'h81, 1'b0, 1'b0);
    repeat (10) @(posedge mclk);
    #1;
    chk1(bus_out.bsy, 1'b0);
  endtask
  // ====================
  // Main sequence
  initial begin
    repeat (8) @(posedge mclk);
    reset_n <= 1'b1;
    t_idle();
    t_wait(8'he4, 8'h83, 1'b0);
    t_wait(8'he5, 8'h42, 1'b1);
    t_nosel();
    t_seq(8'hf7, 8'hc0, 1'b1, 1'b0);
    chk8(sent_cnt, 8'h01);
    chk8(sent_byte, STSW_MSG_DISCONNECT);
    chk1(bus_out.bsy, 1'b0);
    t_seq(8'hf4, 8'h80, 1'b0, 1'b0);
    chk8(sent_cnt, 8'h00);
    chk1(bus_out.bsy, 1'b1);
    t_seq(8'hf4, 8'hc0, 1'b0, 1'b1);
    chk8(sent_cnt, 8'h00);
    t_bad(8'hf4, 8'h01, 8'h00, 1'b0);
    t_bad(8'hf6, 8'hc0, 8'h23, 1'b1);
    t_err(8'he4, 1'b1, STSW_AUX_CONERR);
    t_err(8'hf5, 1'b1, STSW_AUX_CONERR);
    t_err(8'hf6, 1'b0, STSW_AUX_ATNERR);
    t_abort(8'he4);
    t_abort(8'hf4);
    start(8'hf4);
    stsw_ini_inst.pick(8'h55, 1'b1, 1'b0);
    repeat (8) @(posedge mclk);
    #1;
    chk1(initiator_mode, 1'b1);
    stsw_ini_inst.rel();
    wait_aux(STSW_AUX_DONE);
    chk1(bus_out.bsy, 1'b0);
    tally_and_finish();
  end
endmodule
`default_nettype wire
